// File: logic/accel_cfg_params.svh
/*
 Constants of the accelerometer configuration register block: register
 addresses, field positions, reset values, codes and timing figures.
 Assumes it is included by bare name before the package and the modules.
*/
`ifndef ACCEL_CFG_PARAMS_SVH
`define ACCEL_CFG_PARAMS_SVH

`define ACFG_ADDR_DEVICE_CONTROL 8'h0a
`define ACFG_ADDR_DEVICE_CONFIG  8'h0b
`define ACFG_ADDR_AXIS_CONFIG    8'h0c

`define ACFG_RST_DEVICE_CONTROL  8'h00
`define ACFG_RST_DEVICE_CONFIG   8'h00
`define ACFG_RST_AXIS_CONFIG     8'h00

`define ACFG_CTL_RES_HI_BIT      7
`define ACFG_CTL_RES_LO_BIT      6
`define ACFG_CTL_PHASE_MSB       5
`define ACFG_CTL_PHASE_LSB       4
`define ACFG_CTL_PHASE_CFG_BIT   3
`define ACFG_CTL_RSV_MSB         2

`define ACFG_CFG_RAW_BIT         7
`define ACFG_CFG_LOCK_BIT        5
`define ACFG_CFG_UNSIGNED_BIT    4
`define ACFG_CFG_OFFSET_MONITOR_ENABLE_BIT       3
`define ACFG_CFG_ARM_MSB         2

`define ACFG_AX_SELFTEST_BIT     7
`define ACFG_AX_FILTER_MSB       3

`define ACFG_RES_STEP1           2'h0
`define ACFG_RES_STEP2           2'h3
`define ACFG_RES_STEP3           2'h1
`define ACFG_PHASE_NORMAL        2'h3

`define ACFG_ZERO_G_UNSIGNED     10'h200
`define ACFG_ZERO_G_SIGNED       10'h000
`define ACFG_SAMPLE_SHORT_US     5'h08
`define ACFG_SAMPLE_LONG_US      5'h10

`define ACFG_CLK_MHZ             50
`define ACFG_ST_BLANK_TIME_US    16

`endif

// File: logic/accel_cfg_pkg.sv
/*
 Types of the accelerometer configuration register block.
 Assumes accel_cfg_params.svh supplies the constants.
*/
`default_nettype none
package accel_cfg_pkg;

	typedef enum logic [2:0]
	{
		ARM_OFF    = 3'b000,
		ARM_PCM    = 3'b001,
		ARM_AVG    = 3'b010,
		ARM_COUNT  = 3'b100,
		ARM_UNFILT = 3'b110
	} arm_mode_t;

	typedef enum logic [1:0]
	{
		RSQ_IDLE  = 2'b00,
		RSQ_GOT_1 = 2'b01,
		RSQ_GOT_2 = 2'b10
	} rst_step_t;

	typedef struct packed
	{
		logic       valid;
		logic       write;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_cmd_t;

	typedef struct packed
	{
		logic       valid;
		logic [7:0] data;
	} reg_rsp_t;

	typedef struct packed
	{
		logic       valid;
		logic       long_period;
		logic       three_pole;
		logic [9:0] corner_hz;
	} filter_info_t;

	typedef struct packed
	{
		logic [7:0] dctl;
		logic [7:0] dcfg;
		logic [7:0] axis;
		reg_rsp_t   rsp;
		logic       st_prev;
		logic       dev_rst;
	} cfg_state_t;

endpackage
`default_nettype wire

// File: logic/reset_sequence_detect.sv
/*
 Detects the three consecutive reset-control writes 00, 11, 01.
 Assumes one command per valid cycle; any other command breaks the run.
*/
`timescale 1ns/1ps
`default_nettype none
`include "accel_cfg_params.svh"

module reset_sequence_detect
(
	// Clock and reset
	input  wire logic       i_core_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_soft_rst,
	// Command view
	input  wire logic       i_cmd_valid,
	input  wire logic       i_ctl_write,
	input  wire logic [1:0] i_res_bits,
	// Result
	output logic            o_reset_pulse
);
	accel_cfg_pkg::rst_step_t step_r;
	accel_cfg_pkg::rst_step_t step_nxt;

	always_comb
	begin
		step_nxt = step_r;
		o_reset_pulse = 1'b0;
		if (i_cmd_valid)
		begin
			step_nxt = accel_cfg_pkg::RSQ_IDLE; // [RULE_23]
			if (i_ctl_write)
			begin
				case (step_r)
					accel_cfg_pkg::RSQ_GOT_1:
						if (i_res_bits == `ACFG_RES_STEP2)
							step_nxt = accel_cfg_pkg::RSQ_GOT_2;
					accel_cfg_pkg::RSQ_GOT_2:
						o_reset_pulse = (i_res_bits == `ACFG_RES_STEP3); // [RULE_23]
					default: ;
				endcase
				if (i_res_bits == `ACFG_RES_STEP1)
					step_nxt = accel_cfg_pkg::RSQ_GOT_1;
			end
		end
		if (i_soft_rst)
			step_nxt = accel_cfg_pkg::RSQ_IDLE;
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			step_r <= accel_cfg_pkg::RSQ_IDLE;
		else
			step_r <= step_nxt;
	end
endmodule
`default_nettype wire

// File: logic/selftest_blank_timer.sv
/*
 Holds the offset monitor blanked for a fixed count after self test ends.
 Assumes a one-cycle start pulse; clear restarts from idle.
*/
`timescale 1ns/1ps
`default_nettype none

module selftest_blank_timer
#(
	parameter int CYCLES = 800
)
(
	// Clock and reset
	input  wire logic i_core_clk,
	input  wire logic i_rst_n,
	input  wire logic i_clear,
	// Control
	input  wire logic i_start,
	output logic      o_blanking
);
	localparam int W = $clog2(CYCLES + 1);

	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;

	always_comb
	begin
		cnt_nxt = cnt_r;
		if (cnt_r != '0)
			cnt_nxt = cnt_r - 1'b1;
		if (i_start)
			cnt_nxt = W'(CYCLES); // [RULE_18]
		if (i_clear)
			cnt_nxt = '0;
	end

	assign o_blanking = (cnt_r != '0);

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			cnt_r <= '0;
		else
			cnt_r <= cnt_nxt;
	end
endmodule
`default_nettype wire

// File: logic/accel_config_registers.sv
/*
 Configuration register logic of a single-axis accelerometer: device
 control, device configuration and axis configuration registers, the
 initialization lock and its side effects, self-test timing and the
 three-write reset sequence.
 Assumes serial framing is decoded outside into one command per cycle,
 synchronous to i_core_clk; the answer follows one cycle later.
*/
// What the document requires of this block and of its host
// [RULE_01] Device config register writable until the lock bit is set, then rejected.
// [RULE_02] Writable-register check enabled only when locked; covers both config registers.
// [RULE_03] Config bit 7 picks data: 0 offset-cancelled, 1 raw.
// [RULE_04] Offset-cancelled output forces the offset monitor on.
// [RULE_05] Host writes zero to config bit 6.
// [RULE_06] Once locked, only the device control register still takes writes; here locked control writes are dropped too, only the reset sequence sees them.
// [RULE_07] Lock bit stays set until a device reset.
// [RULE_08] Locking forces normal offset phase; stored phase bits stay unchanged.
// [RULE_09] Locking disables self test; stored enable bit keeps its value.
// [RULE_10] Locked writes keep self-test bit; answers show last written value.
// [RULE_11] Bit 4: 1 unsigned, zero at 512; 0 signed, zero at 0.
// [RULE_12] Bit 3 enables offset monitor, unless offset-cancelled output forces it.
// [RULE_13] Bits 2:0 choose arming pin mode and polarity.
// [RULE_14] Axis config register writable only before lock.
// [RULE_15] Self test runs only if enabled and not locked; reads positive.
// [RULE_16] Every internal reset clears the self-test enable.
// [RULE_17] Active self test suspends offset cancellation and monitor; status shows it.
// [RULE_18] Self test off: status clears at once; monitor blanked a fixed time.
// [RULE_19] Host writes zeros to axis config bits 6 to 4.
// [RULE_20] Filter codes 0-5 sample at 8 us, 8-13 at 16 us; others reserved.
// [RULE_21] Filter codes map to fixed corner frequencies and pole counts.
// [RULE_22] Host never writes a reserved filter code.
// [RULE_23] Writes 00, 11, 01 to reset bits in a row reset; a read aborts.
`timescale 1ns/1ps
`default_nettype none
`include "accel_cfg_params.svh"

module accel_config_registers
#(
	parameter int CLK_MHZ       = `ACFG_CLK_MHZ,
	parameter int BLANK_TIME_US = `ACFG_ST_BLANK_TIME_US
)
(
	// Clock and reset
	input  wire logic                    i_core_clk,
	input  wire logic                    i_rst_n,
	// Register command port
	input  wire accel_cfg_pkg::reg_cmd_t i_cmd,
	output accel_cfg_pkg::reg_rsp_t      o_rsp,
	// Data path configuration
	output logic                         o_raw_data_select,
	output logic                         o_unsigned_format_select,
	output logic [9:0]                   o_zero_g_level,
	output logic                         o_offset_monitor_enable,
	output logic                         o_offset_cancel_suspend,
	output logic [1:0]                   o_offset_phase,
	output logic                         o_offset_phase_hold,
	// Arming pin
	output accel_cfg_pkg::arm_mode_t     o_arm_mode,
	output logic                         o_arm_active_low,
	output logic                         o_arm_pin_enable,
	// Filter
	output logic [3:0]                   o_filter_select,
	output accel_cfg_pkg::filter_info_t  o_filter_info,
	output logic [4:0]                   o_sample_period_us,
	// Self test and status
	output logic                         o_self_test_active,
	output logic                         o_init_done_lock,
	// Writable register check
	output logic                         o_crc_enable,
	output logic [15:0]                  o_crc_data,
	// Device reset request
	output logic                         o_device_reset
);
	localparam int BLANK_CYCLES_RAW = BLANK_TIME_US * CLK_MHZ;
	localparam int BLANK_CYCLES     = (BLANK_CYCLES_RAW < 1) ? 1 : BLANK_CYCLES_RAW;

	accel_cfg_pkg::cfg_state_t st_r;
	accel_cfg_pkg::cfg_state_t st_nxt;

	logic       locked;
	logic       wr;
	logic       wr_ctl;
	logic       wr_cfg;
	logic       wr_axis;
	logic       seq_reset;
	logic       st_active;
	logic       st_falls;
	logic       blanking;
	logic [1:0] res_bits;
	logic [1:0] sel;

	// Filter code to corner, poles and sample period
	function automatic accel_cfg_pkg::filter_info_t filter_decode(input logic [3:0] code);
		accel_cfg_pkg::filter_info_t f;
		f = '0;
		f.valid = 1'b1;
		f.long_period = code[3]; // [RULE_20]
		case (code[2:0]) // [RULE_21]
			3'h0: f.corner_hz = code[3] ? 10'h032 : 10'h064;
			3'h1: f.corner_hz = code[3] ? 10'h096 : 10'h12c;
			3'h2: f.corner_hz = code[3] ? 10'h0c8 : 10'h190;
			3'h3: f.corner_hz = code[3] ? 10'h190 : 10'h320;
			3'h4: f.corner_hz = code[3] ? 10'h1f4 : 10'h3e8;
			3'h5:
			begin
				f.corner_hz = code[3] ? 10'h0c8 : 10'h190;
				f.three_pole = 1'b1;
			end
			default:
			begin
				// Reserved codes: flagged invalid, corner left at zero
				f.valid = 1'b0; // [RULE_20]
			end
		endcase
		return f;
	endfunction

	// Register picked by a command address: 1 control, 2 config, 3 axis, 0 none
	function automatic logic [1:0] reg_sel(input logic [7:0] addr);
		logic [1:0] s;
		s = 2'h0;
		if (addr == `ACFG_ADDR_DEVICE_CONTROL)
		begin
			s = 2'h1;
		end
		else if (addr == `ACFG_ADDR_DEVICE_CONFIG)
		begin
			s = 2'h2;
		end
		else if (addr == `ACFG_ADDR_AXIS_CONFIG)
		begin
			s = 2'h3;
		end
		return s;
	endfunction

	assign locked   = st_r.dcfg[`ACFG_CFG_LOCK_BIT];
	assign wr       = i_cmd.valid & i_cmd.write;
	assign sel      = reg_sel(i_cmd.addr);
	assign wr_ctl   = wr & (sel == 2'h1);
	assign wr_cfg   = wr & (sel == 2'h2);
	assign wr_axis  = wr & (sel == 2'h3);
	assign res_bits = {i_cmd.wdata[`ACFG_CTL_RES_HI_BIT], i_cmd.wdata[`ACFG_CTL_RES_LO_BIT]};

	// Any command other than the next expected control write breaks the run
	reset_sequence_detect u_rst_seq
	(
		.i_core_clk    (i_core_clk),
		.i_rst_n       (i_rst_n),
		.i_soft_rst    (1'b0),
		.i_cmd_valid   (i_cmd.valid),
		.i_ctl_write   (wr_ctl),
		.i_res_bits    (res_bits),
		.o_reset_pulse (seq_reset)
	);

	// Effective self test: stored enable gated by the lock
	assign st_active = st_r.axis[`ACFG_AX_SELFTEST_BIT] & ~locked; // [RULE_09] [RULE_15]
	assign st_falls  = st_r.st_prev & ~st_active;

	selftest_blank_timer
	#(
		.CYCLES (BLANK_CYCLES)
	)
	u_blank
	(
		.i_core_clk (i_core_clk),
		.i_rst_n    (i_rst_n),
		.i_clear    (st_r.dev_rst),
		.i_start    (st_falls),
		.o_blanking (blanking)
	);

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.rsp.valid = i_cmd.valid;
		st_nxt.rsp.data = 8'h00;
		st_nxt.st_prev = st_active;
		st_nxt.dev_rst = seq_reset;

		// Answer shows contents before this command takes effect
		if (i_cmd.valid)
		begin
			if (sel == 2'h1)
			begin
				// Reset bits always read back as zero
				st_nxt.rsp.data = {2'b00, st_r.dctl[`ACFG_CTL_PHASE_MSB:0]}; // [RULE_23]
			end
			else if (sel == 2'h2)
			begin
				st_nxt.rsp.data = st_r.dcfg;
			end
			else if (sel == 2'h3)
			begin
				st_nxt.rsp.data = st_r.axis; // [RULE_10]
			end
		end

		// Control register: reset bits always taken, low bits only before lock
		if (wr_ctl && !locked) // [RULE_06] [RULE_08]
		begin
			st_nxt.dctl[`ACFG_CTL_PHASE_CFG_BIT] = i_cmd.wdata[`ACFG_CTL_PHASE_CFG_BIT];
			st_nxt.dctl[`ACFG_CTL_RSV_MSB:0] = i_cmd.wdata[`ACFG_CTL_RSV_MSB:0];
			if (i_cmd.wdata[`ACFG_CTL_PHASE_CFG_BIT])
			begin
				st_nxt.dctl[`ACFG_CTL_PHASE_MSB:`ACFG_CTL_PHASE_LSB] =
					i_cmd.wdata[`ACFG_CTL_PHASE_MSB:`ACFG_CTL_PHASE_LSB];
			end
		end

		// Lock can only be set here; once set, writes here are dropped
		if (wr_cfg && !locked) // [RULE_01] [RULE_07]
		begin
			st_nxt.dcfg = i_cmd.wdata;
		end

		if (wr_axis && !locked) // [RULE_14] [RULE_10]
		begin
			st_nxt.axis = i_cmd.wdata;
		end

		// Internal reset from the write sequence: back to reset values
		if (seq_reset) // [RULE_07] [RULE_16]
		begin
			st_nxt.dctl = `ACFG_RST_DEVICE_CONTROL;
			st_nxt.dcfg = `ACFG_RST_DEVICE_CONFIG;
			st_nxt.axis = `ACFG_RST_AXIS_CONFIG;
			st_nxt.st_prev = 1'b0;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			st_r.dctl <= `ACFG_RST_DEVICE_CONTROL;
			st_r.dcfg <= `ACFG_RST_DEVICE_CONFIG;
			st_r.axis <= `ACFG_RST_AXIS_CONFIG; // [RULE_16]
			st_r.rsp <= '0;
			st_r.st_prev <= 1'b0;
			st_r.dev_rst <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign o_rsp          = st_r.rsp;
	assign o_device_reset = st_r.dev_rst; // [RULE_23]

	// Data format
	assign o_raw_data_select        = st_r.dcfg[`ACFG_CFG_RAW_BIT]; // [RULE_03]
	assign o_unsigned_format_select = st_r.dcfg[`ACFG_CFG_UNSIGNED_BIT];
	assign o_zero_g_level = o_unsigned_format_select ?
		`ACFG_ZERO_G_UNSIGNED : `ACFG_ZERO_G_SIGNED; // [RULE_11]

	// Monitor: forced on for cancelled data, off during and after self test
	always_comb
	begin
		o_offset_monitor_enable =
			~st_r.dcfg[`ACFG_CFG_RAW_BIT] | st_r.dcfg[`ACFG_CFG_OFFSET_MONITOR_ENABLE_BIT]; // [RULE_04] [RULE_12]
		// Cycle right after the drop comes before the timer has loaded
		if (st_active || st_r.st_prev || blanking)
		begin
			o_offset_monitor_enable = 1'b0; // [RULE_17] [RULE_18]
		end
	end
	assign o_offset_cancel_suspend = st_active; // [RULE_17]
	assign o_self_test_active      = st_active; // [RULE_17] [RULE_18]

	// Phase: normal once locked, stored bits themselves untouched
	assign o_offset_phase = locked ? `ACFG_PHASE_NORMAL
		: st_r.dctl[`ACFG_CTL_PHASE_MSB:`ACFG_CTL_PHASE_LSB]; // [RULE_08]
	assign o_offset_phase_hold = st_r.dctl[`ACFG_CTL_PHASE_CFG_BIT] & ~locked; // [RULE_08]

	// Arming pin decode; bit 0 is polarity for the three threshold modes
	always_comb
	begin
		o_arm_active_low = 1'b0;
		case (st_r.dcfg[`ACFG_CFG_ARM_MSB:1]) // [RULE_13]
			2'h0:
			begin
				o_arm_mode = st_r.dcfg[0] ? accel_cfg_pkg::ARM_PCM : accel_cfg_pkg::ARM_OFF;
			end
			2'h1:
			begin
				o_arm_mode = accel_cfg_pkg::ARM_AVG;
				o_arm_active_low = st_r.dcfg[0];
			end
			2'h2:
			begin
				o_arm_mode = accel_cfg_pkg::ARM_COUNT;
				o_arm_active_low = st_r.dcfg[0];
			end
			default:
			begin
				o_arm_mode = accel_cfg_pkg::ARM_UNFILT;
				o_arm_active_low = st_r.dcfg[0];
			end
		endcase
	end
	// Mode 000 leaves the pin at high impedance
	assign o_arm_pin_enable = (o_arm_mode != accel_cfg_pkg::ARM_OFF); // [RULE_13]

	// Filter
	assign o_filter_select = st_r.axis[`ACFG_AX_FILTER_MSB:0];
	assign o_filter_info   = filter_decode(o_filter_select); // [RULE_21]
	assign o_sample_period_us = o_filter_select[3] ?
		`ACFG_SAMPLE_LONG_US : `ACFG_SAMPLE_SHORT_US; // [RULE_20]

	// Check runs only when locked, over both configuration registers
	assign o_init_done_lock = locked;
	assign o_crc_enable     = locked; // [RULE_02]
	assign o_crc_data       = {st_r.dcfg, st_r.axis}; // [RULE_02]
endmodule
`default_nettype wire

// File: verif/accel_cfg_checker_assertions.sv
/*
 Concurrent checks of the configuration register block.
 Assumes it is bound to accel_config_registers and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
`include "accel_cfg_params.svh"

module accel_cfg_checker
#(
	parameter int CLK_MHZ       = 50,
	parameter int BLANK_TIME_US = 16
)
(
	// Clock and reset
	input wire logic                    i_core_clk,
	input wire logic                    i_rst_n,
	// Command port
	input wire accel_cfg_pkg::reg_cmd_t i_cmd,
	input wire accel_cfg_pkg::reg_rsp_t o_rsp,
	// Outputs watched
	input wire logic                    o_raw_data_select,
	input wire logic                    o_unsigned_format_select,
	input wire logic [9:0]              o_zero_g_level,
	input wire logic                    o_offset_monitor_enable,
	input wire logic [1:0]              o_offset_phase,
	input wire logic [3:0]              o_filter_select,
	input wire logic [4:0]              o_sample_period_us,
	input wire logic                    o_self_test_active,
	input wire logic                    o_init_done_lock,
	input wire logic                    o_crc_enable,
	input wire logic [15:0]             o_crc_data,
	input wire logic                    o_device_reset
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	logic cfg_acc;
	logic ax_wr;
	assign cfg_acc = i_cmd.valid && i_cmd.addr == `ACFG_ADDR_DEVICE_CONFIG;
	assign ax_wr   = i_cmd.valid && i_cmd.write && i_cmd.addr == `ACFG_ADDR_AXIS_CONFIG;

	// Lock also ends self test, so it blanks the monitor too
	sequence st_drop;
		$fell(o_self_test_active) && !o_device_reset;
	endsequence
	sequence mon_blank;
		(!o_offset_monitor_enable) [*8];
	endsequence

	// Mirror of the blanking window, reloaded on each fall of self test that does not come with a device reset
	localparam int BLANK_CYCLES = BLANK_TIME_US * CLK_MHZ;
	int   blank_cnt;
	logic st_q;
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			st_q <= 1'b0;
			blank_cnt <= 0;
		end
		else
		begin
			st_q <= o_self_test_active;
			if (o_device_reset)
				blank_cnt <= 0;
			else if (st_q && !o_self_test_active)
				blank_cnt <= BLANK_CYCLES;
			else if (blank_cnt > 0)
				blank_cnt <= blank_cnt - 1;
		end
	end

	AST_RSP_NEXT: assert property (i_cmd.valid |=> o_rsp.valid)
		else $error("answer missing one cycle after command");
	AST_CFG_READ: assert property (cfg_acc && !i_cmd.write |=> o_rsp.data == $past(o_crc_data[15:8]))
		else $error("config read answer differs from contents");
	AST_CFG_LOCKED: assert property (o_init_done_lock && cfg_acc && i_cmd.write |=> $stable(o_crc_data[15:8]))
		else $error("locked config register changed");
	AST_AX_LOCKED: assert property (o_init_done_lock && ax_wr |=> $stable(o_crc_data[7:0]))
		else $error("locked axis register changed");
	AST_LOCK_STICKY: assert property (o_init_done_lock |=> o_init_done_lock || o_device_reset)
		else $error("lock cleared without reset");
	AST_CRC_EN: assert property (o_crc_enable == o_init_done_lock && o_crc_data[13] == o_init_done_lock)
		else $error("check enable not tied to lock");
	AST_PHASE_NORMAL: assert property (o_init_done_lock |-> o_offset_phase == `ACFG_PHASE_NORMAL)
		else $error("phase not normal while locked");
	AST_ST_LOCKED: assert property (o_init_done_lock |-> !o_self_test_active)
		else $error("self test active while locked");
	AST_ST_ON: assert property (!o_init_done_lock && ax_wr && i_cmd.wdata[7] |=> o_self_test_active)
		else $error("self test not started");
	AST_ZERO_G: assert property (o_zero_g_level == (o_unsigned_format_select ? 10'h200 : 10'h000))
		else $error("zero level wrong");
	AST_SAMPLE: assert property (o_sample_period_us == (o_filter_select[3] ? 5'h10 : 5'h08))
		else $error("sample period wrong");
	AST_RAW_SEL: assert property (o_raw_data_select == o_crc_data[15])
		else $error("raw select not from bit 7");
	AST_MON: assert property (o_offset_monitor_enable |-> (!o_raw_data_select || o_crc_data[11]) && !o_self_test_active)
		else $error("monitor enabled wrongly");
	AST_BLANK: assert property (st_drop |-> mon_blank)
		else $error("monitor not blanked after self test");
	AST_BLANK_LEN: assert property (blank_cnt > 0 |-> !o_offset_monitor_enable)
		else $error("monitor enabled inside blanking time");
	AST_DEV_RST: assert property (o_device_reset |-> o_crc_data == 16'h0000 ##1 !o_device_reset)
		else $error("device reset pulse wrong");
endmodule

bind accel_config_registers accel_cfg_checker
#(
	.CLK_MHZ       (CLK_MHZ),
	.BLANK_TIME_US (BLANK_TIME_US)
)
chk_u
(
	.i_core_clk               (i_core_clk),
	.i_rst_n                  (i_rst_n),
	.i_cmd                    (i_cmd),
	.o_rsp                    (o_rsp),
	.o_raw_data_select        (o_raw_data_select),
	.o_unsigned_format_select (o_unsigned_format_select),
	.o_zero_g_level           (o_zero_g_level),
	.o_offset_monitor_enable  (o_offset_monitor_enable),
	.o_offset_phase           (o_offset_phase),
	.o_filter_select          (o_filter_select),
	.o_sample_period_us       (o_sample_period_us),
	.o_self_test_active       (o_self_test_active),
	.o_init_done_lock         (o_init_done_lock),
	.o_crc_enable             (o_crc_enable),
	.o_crc_data               (o_crc_data),
	.o_device_reset           (o_device_reset)
);
`default_nettype wire

// File: verif/cfg_host_model.sv
/*
 Host model: issues one register command and waits for its answer.
 Assumes the block answers one cycle after taking a command.
*/
`timescale 1ns/1ps
`default_nettype none
`include "accel_cfg_params.svh"

module cfg_host_model
(
	// Clock
	input  wire logic                    i_core_clk,
	// Command port
	output var accel_cfg_pkg::reg_cmd_t  o_cmd,
	input  wire accel_cfg_pkg::reg_rsp_t i_rsp
);
	initial o_cmd = '0;

	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic ok);
		int n;
		logic [7:0] v;
		v = d;
		if (a == `ACFG_ADDR_DEVICE_CONFIG)
			v[6] = 1'b0;
		if (a == `ACFG_ADDR_AXIS_CONFIG)
			v[6:4] = 3'h0;
		if (a == `ACFG_ADDR_AXIS_CONFIG && v[2:1] == 2'h3)
			v[3:0] = 4'h0;
		@(posedge i_core_clk);
		o_cmd <= '{1'b1, w, a, v};
		@(posedge i_core_clk);
		// Idle lines show the inverse, never a stale copy
		o_cmd <= '{1'b0, ~w, ~a, ~v};
		#1;
		n = 0;
		while (!i_rsp.valid && n < 4)
		begin
			@(posedge i_core_clk);
			#1;
			n++;
		end
		ok = i_rsp.valid;
		q = i_rsp.data;
	endtask
endmodule
`default_nettype wire

// File: verif/accel_config_registers_tb.sv
/*
 Self-checking bench of the configuration register block.
 Assumes the host model drives commands; blanking shortened to 50 cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module accel_config_registers_tb;
	logic                        i_core_clk;
	logic                        i_rst_n;
	accel_cfg_pkg::reg_cmd_t     cmd;
	accel_cfg_pkg::reg_rsp_t     rsp;
	accel_cfg_pkg::arm_mode_t    arm;
	accel_cfg_pkg::filter_info_t finfo;
	logic                        raw, uns, mon, sus, hold, alow, pen, st, lock, crce, drst;
	logic [9:0]                  zg;
	logic [1:0]                  ph;
	logic [3:0]                  fsel;
	logic [4:0]                  per;
	logic [15:0]                 crcd;
	logic [7:0]                  q, d;
	logic [2:0]                  c;
	logic [3:0]                  f;
	logic [9:0]                  hz [16];
	int                          error_cnt = 0;
	int                          check_count = 0;

	cfg_host_model host_u (.i_core_clk(i_core_clk), .o_cmd(cmd), .i_rsp(rsp));

	accel_config_registers #(.BLANK_TIME_US(1)) dut_u
	(
		.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_cmd(cmd), .o_rsp(rsp),
		.o_raw_data_select(raw), .o_unsigned_format_select(uns), .o_zero_g_level(zg),
		.o_offset_monitor_enable(mon), .o_offset_cancel_suspend(sus), .o_offset_phase(ph),
		.o_offset_phase_hold(hold), .o_arm_mode(arm), .o_arm_active_low(alow),
		.o_arm_pin_enable(pen), .o_filter_select(fsel), .o_filter_info(finfo),
		.o_sample_period_us(per), .o_self_test_active(st), .o_init_done_lock(lock),
		.o_crc_enable(crce), .o_crc_data(crcd), .o_device_reset(drst)
	);

	initial
	begin
		i_core_clk = 1'b0;
		forever #10 i_core_clk = ~i_core_clk;
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic acc(input int w, input logic [7:0] a, input logic [7:0] v);
		logic ok;
		host_u.xfer(w[0], a, v, q, ok);
		if (ok !== 1'b1)
		begin
			error_cnt++;
			summarize();
		end
	endtask

	// Optional read between second and third write must abort the run
	task automatic rseq(input logic abort);
		acc(1, 8'h0a, 8'h00);
		acc(1, 8'h0a, 8'hc0);
		if (abort)
			acc(0, 8'h0a, 8'h00);
		acc(1, 8'h0a, 8'h40);
	endtask

	initial
	begin
		hz = '{10'h064, 10'h12c, 10'h190, 10'h320, 10'h3e8, 10'h190, 10'h000, 10'h000,
			10'h032, 10'h096, 10'h0c8, 10'h190, 10'h1f4, 10'h0c8, 10'h000, 10'h000};
		i_rst_n = 1'b0;
		repeat (6) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		chk(mon, 1'b1);
		for (int a = 10; a < 14; a++)
		begin
			acc(0, a[7:0], 8'h00);
			chk(q, 8'h00);
		end
		for (int i = 0; i < 8; i++)
		begin
			c = i[2:0];
			d = {c[0], 2'h0, c[1], c[2], c};
			acc(1, 8'h0b, d);
			chk(arm, (c == 3'h1) ? 3'h1 : {c[2:1], 1'b0});
			chk({alow, pen}, {c[0] && c[2:1] != 2'h0, c != 3'h0});
			chk(raw, c[0]);
			chk({uns, zg}, {c[1], c[1] ? 10'h200 : 10'h000});
			chk(mon, !c[0] || c[2]);
			acc(0, 8'h0b, 8'h00);
			chk(q, d);
		end
		for (int i = 0; i < 16; i++)
		begin
			f = i[3:0];
			if (f[2:1] != 2'h3)
			begin
				acc(1, 8'h0c, {4'h0, f});
				chk(per, f[3] ? 5'h10 : 5'h08);
				chk(fsel, f);
				chk(finfo, {1'b1, f[3], f[2:0] == 3'h5, hz[i]});
			end
		end
		acc(1, 8'h0b, 8'h00);
		acc(1, 8'h0c, 8'h80);
		chk({st, sus, mon}, 3'h6);
		acc(1, 8'h0c, 8'h00);
		chk({st, sus, mon}, 3'h0);
		#800;
		chk(mon, 1'b0);
		#400;
		chk(mon, 1'b1);
		acc(1, 8'h0a, 8'h28);
		chk({ph, hold}, 3'h5);
		acc(1, 8'h0a, 8'h10);
		chk({ph, hold}, 3'h4);
		acc(1, 8'h0c, 8'h85);
		acc(1, 8'h0b, 8'h20);
		chk({lock, crce, ph, st}, 5'h1e);
		chk(crcd, 16'h2085);
		acc(1, 8'h0b, 8'h00);
		acc(1, 8'h0c, 8'h0a);
		acc(1, 8'h0a, 8'h3f);
		chk(q, 8'h20);
		acc(0, 8'h0a, 8'h00);
		chk(q, 8'h20);
		acc(0, 8'h0b, 8'h00);
		chk(q, 8'h20);
		acc(0, 8'h0c, 8'h00);
		chk(q, 8'h85);
		rseq(1'b1);
		chk({drst, lock}, 2'h1);
		rseq(1'b0);
		chk({drst, lock}, 2'h2);
		acc(0, 8'h0c, 8'h00);
		chk(q, 8'h00);
		summarize();
	end
endmodule
`default_nettype wire
